// File: gtsp_defs.svh
// Register indices, bit masks and reset values for the two-port GPIO
`ifndef GTSP_DEFS_SVH
`define GTSP_DEFS_SVH

// Register indices; byte address on APB is four times the index
`define GTSP_IDX_NLAT 14'h0009
`define GTSP_IDX_WLAT 14'h000b
`define GTSP_IDX_NPRD 14'h0016
`define GTSP_IDX_WPRD 14'h0018
`define GTSP_IDX_NDIR 14'h0f23
`define GTSP_IDX_WDIR 14'h0f25
`define GTSP_IDX_NPU 14'h0f30
`define GTSP_IDX_NFS 14'h0f3d
`define GTSP_IDX_WFS 14'h0f3f
`define GTSP_IDX_NODT 14'h0f4a
`define GTSP_IDX_WODT 14'h0f4c

// Implemented bits of each port
`define GTSP_NMASK 8'h03
`define GTSP_WMASK 8'hf0
`define GTSP_WFSMASK 8'h70

// Reset values
`define GTSP_RST 8'h00
`define GTSP_OE_REL 8'hff

`endif

// File: gtsp_pins.sv
// Pin-level model of the wires outside both GPIO ports
`timescale 1ns/10ps

module gtsp_pins (
   input wire logic clock,
   input wire gtsp_pkg::gtsp_pad_t narrow_pad,
   input wire gtsp_pkg::gtsp_pad_t wide_pad,
   input wire logic [7:0] n_ext,
   input wire logic [7:0] n_en,
   input wire logic [7:0] w_ext,
   input wire logic [7:0] w_en,
   output logic [1:0] narrow_pin_in,
   output logic [3:0] wide_pin_in
);
   logic [7:0] n_lvl;
   logic [7:0] w_lvl;
   logic [7:0] n_last_q = 8'h00;
   logic [7:0] w_last_q = 8'h00;

   // Pad drive wins, then outside driver, then pull-up; a floating pin
   // flips every cycle so a stale value never passes for a real one
   function automatic logic [7:0] wire_lvl(gtsp_pkg::gtsp_pad_t p,
      logic [7:0] x, logic [7:0] en, logic [7:0] last);
      return (~p.oe_n & p.out) | (p.oe_n & en & x) |
         (p.oe_n & ~en & (p.pull_en | ~last));
   endfunction

   // Levels seen on both ports
   assign n_lvl = wire_lvl(narrow_pad, n_ext, n_en, n_last_q);
   assign w_lvl = wire_lvl(wide_pad, w_ext, w_en, w_last_q);
   assign narrow_pin_in = n_lvl[1:0];
   assign wide_pin_in = w_lvl[7:4];

   // Remember last level for the floating pattern
   always_ff @(posedge clock) begin
      n_last_q <= n_lvl;
      w_last_q <= w_lvl;
   end
endmodule

// File: gtsp_pkg.sv
// Types shared by the two-port GPIO
package gtsp_pkg;

   // One port's pad controls, bit i drives pin i
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
      logic [7:0] pull_en;
   } gtsp_pad_t;

endpackage

// File: gtsp_top.sv
// Two-port GPIO with APB register access and serial pin sharing
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "gtsp_defs.svh"

// What this block does
// - Narrow direction: 0 input feeds UART1, 1 output
// - Narrow select: 0 latch, 1 UART1 transmit
// - Narrow drive type: 0 push-pull, 1 open drain
// - Narrow pull-up only in input or open drain
// - Push-pull output keeps pull-up disconnected
// - Narrow pin read: level, or 0 if push-pull output
// - Wide direction bits 7..4, low bits zero
// - Wide drive type: 0 push-pull, 1 open drain
// - Wide latch drives level in output mode
// - Wide select: serial clock, UART0 or serial data
// - Wide pin read: level, or 0 if push-pull output
// - Narrow latch drives level, open drain releases high
module gtsp_top (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] narrow_pin_in,
   input wire logic [3:0] wide_pin_in,
   input wire logic uart1_transmit_out,
   input wire logic uart0_transmit_out,
   input wire logic serial_clock_line,
   input wire logic serial_data_out,
   input wire logic wide_b4_serial_sel,
   output gtsp_pkg::gtsp_pad_t narrow_pad,
   output gtsp_pkg::gtsp_pad_t wide_pad,
   output logic [1:0] uart1_receive_in,
   output logic uart0_receive_in,
   output logic serial_data_in
);

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // Pin synchronisers, the first stage is read only by the second
   logic [7:0] nsync1_q;
   logic [7:0] nsync2_q;
   logic [7:0] wsync1_q;
   logic [7:0] wsync2_q;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         nsync1_q <= `GTSP_RST;
         nsync2_q <= `GTSP_RST;
         wsync1_q <= `GTSP_RST;
         wsync2_q <= `GTSP_RST;
      end else begin
         nsync1_q <= {6'h00, narrow_pin_in};
         nsync2_q <= nsync1_q;
         wsync1_q <= {wide_pin_in, 4'h0};
         wsync2_q <= wsync1_q;
      end
   end

   // APB decode; one wait state so every answer leaves a flop
   logic pready_q;
   logic access;
   logic pready_d;
   logic aligned;
   logic [13:0] idx;
   logic wr_fire;

   assign access = psel & penable;
   assign pready_d = access & ~pready_q;
   assign aligned = (paddr[1:0] == 2'h0);
   assign idx = paddr[15:2];
   // Only the low byte lane holds data; a write without it is a no-op
   assign wr_fire = access & pready_q & pwrite & pstrb[0];

   logic h_nlat;
   logic h_wlat;
   logic h_nprd;
   logic h_wprd;
   logic h_ndir;
   logic h_wdir;
   logic h_npu;
   logic h_nfs;
   logic h_wfs;
   logic h_nodt;
   logic h_wodt;
   logic mapped;

   // Register address hits
   assign h_nlat = aligned & (idx == `GTSP_IDX_NLAT);
   assign h_wlat = aligned & (idx == `GTSP_IDX_WLAT);
   assign h_nprd = aligned & (idx == `GTSP_IDX_NPRD);
   assign h_wprd = aligned & (idx == `GTSP_IDX_WPRD);
   assign h_ndir = aligned & (idx == `GTSP_IDX_NDIR);
   assign h_wdir = aligned & (idx == `GTSP_IDX_WDIR);
   assign h_npu = aligned & (idx == `GTSP_IDX_NPU);
   assign h_nfs = aligned & (idx == `GTSP_IDX_NFS);
   assign h_wfs = aligned & (idx == `GTSP_IDX_WFS);
   assign h_nodt = aligned & (idx == `GTSP_IDX_NODT);
   assign h_wodt = aligned & (idx == `GTSP_IDX_WODT);
   assign mapped = h_nlat | h_wlat | h_nprd | h_wprd | h_ndir |
                   h_wdir | h_npu | h_nfs | h_wfs | h_nodt | h_wodt;

   // Control registers
   logic [7:0] nlat_q;
   logic [7:0] wlat_q;
   logic [7:0] ndir_q;
   logic [7:0] wdir_q;
   logic [7:0] npu_q;
   logic [7:0] nfs_q;
   logic [7:0] wfs_q;
   logic [7:0] nodt_q;
   logic [7:0] wodt_q;
   logic [7:0] nlat_d;
   logic [7:0] wlat_d;
   logic [7:0] ndir_d;
   logic [7:0] wdir_d;
   logic [7:0] npu_d;
   logic [7:0] nfs_d;
   logic [7:0] wfs_d;
   logic [7:0] nodt_d;
   logic [7:0] wodt_d;
   logic [7:0] wb;

   // Writes land at the pready edge, masked to implemented bits
   assign wb = pwdata[7:0];
   assign nlat_d = (wr_fire & h_nlat) ? (wb & `GTSP_NMASK) :
                   nlat_q;
   assign wlat_d = (wr_fire & h_wlat) ? (wb & `GTSP_WMASK) :
                   wlat_q;
   assign ndir_d = (wr_fire & h_ndir) ? (wb & `GTSP_NMASK) :
                   ndir_q;
   assign wdir_d = (wr_fire & h_wdir) ? (wb & `GTSP_WMASK) :
                   wdir_q;
   assign npu_d = (wr_fire & h_npu) ? (wb & `GTSP_NMASK) : npu_q;
   assign nfs_d = (wr_fire & h_nfs) ? (wb & `GTSP_NMASK) : nfs_q;
   assign wfs_d = (wr_fire & h_wfs) ? (wb & `GTSP_WFSMASK) :
                  wfs_q;
   assign nodt_d = (wr_fire & h_nodt) ? (wb & `GTSP_NMASK) :
                   nodt_q;
   assign wodt_d = (wr_fire & h_wodt) ? (wb & `GTSP_WMASK) :
                   wodt_q;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         nlat_q <= `GTSP_RST;
         wlat_q <= `GTSP_RST;
         ndir_q <= `GTSP_RST;
         wdir_q <= `GTSP_RST;
         npu_q <= `GTSP_RST;
         nfs_q <= `GTSP_RST;
         wfs_q <= `GTSP_RST;
         nodt_q <= `GTSP_RST;
         wodt_q <= `GTSP_RST;
      end else begin
         nlat_q <= nlat_d;
         wlat_q <= wlat_d;
         ndir_q <= ndir_d;
         wdir_q <= wdir_d;
         npu_q <= npu_d;
         nfs_q <= nfs_d;
         wfs_q <= wfs_d;
         nodt_q <= nodt_d;
         wodt_q <= wodt_d;
      end
   end

   // Pin-read values: level unless driving push-pull
   logic [7:0] nread;
   logic [7:0] wread;
   assign nread = nsync2_q & (~ndir_q | nodt_q) & `GTSP_NMASK;
   assign wread = wsync2_q & (~wdir_q | wodt_q) & `GTSP_WMASK;

   // Read mux; unmapped reads return zero with an error
   logic [7:0] rd_byte;
   logic [31:0] prdata_d;
   logic pslverr_d;
   assign rd_byte = h_nlat ? nlat_q :
                    h_wlat ? wlat_q :
                    h_nprd ? nread :
                    h_wprd ? wread :
                    h_ndir ? ndir_q :
                    h_wdir ? wdir_q :
                    h_npu ? npu_q :
                    h_nfs ? nfs_q :
                    h_wfs ? wfs_q :
                    h_nodt ? nodt_q :
                    h_wodt ? wodt_q : `GTSP_RST;
   assign prdata_d = (pready_d & ~pwrite) ? {24'h000000, rd_byte} :
                     prdata;
   assign pslverr_d = pready_d & ~mapped;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pready_q <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready_q <= pready_d;
         prdata <= prdata_d;
         pslverr <= pslverr_d;
      end
   end
   assign pready = pready_q;

   // Narrow port pad: select source, then drive per mode
   logic [7:0] nval;
   logic [7:0] noe_n;
   logic [7:0] npull;
   assign nval = (nfs_q & {8{uart1_transmit_out}}) |
                 (~nfs_q & nlat_q);
   // Open drain only sinks; a 1 releases the pin
   assign noe_n = ~ndir_q | (nodt_q & nval);
   // Pull-up never fights a push-pull driver
   assign npull = npu_q & (~ndir_q | nodt_q);

   // Wide port pad; bit 4 source comes from the external routing choice
   logic [7:0] wper;
   logic [7:0] wval;
   logic [7:0] woe_n;
   assign wper = {1'b0, serial_clock_line, uart0_transmit_out,
                  wide_b4_serial_sel ? serial_data_out : uart0_transmit_out,
                  4'h0};
   assign wval = (wfs_q & wper) | (~wfs_q & wlat_q);
   assign woe_n = ~wdir_q | (wodt_q & wval);

   // Receive lines idle high while their pin is an output
   logic [1:0] nrx_d;
   assign nrx_d = nsync2_q[1:0] | ndir_q[1:0];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         narrow_pad <= {`GTSP_RST, `GTSP_OE_REL, `GTSP_RST};
         wide_pad <= {`GTSP_RST, `GTSP_OE_REL, `GTSP_RST};
         uart1_receive_in <= 2'h3;
         uart0_receive_in <= 1'b1;
         serial_data_in <= 1'b1;
      end else begin
         narrow_pad <= {nval, noe_n, npull};
         wide_pad <= {wval, woe_n, `GTSP_RST};
         uart1_receive_in <= nrx_d;
         uart0_receive_in <= wsync2_q[5] | wdir_q[5];
         serial_data_in <= wsync2_q[5] | wdir_q[5];
      end
   end

   // Checks on pad behaviour and register access
   // Sampled reset keeps the release edge out, the pads still held there
   chk_dir_input: assert property (
      !rst && !ndir_q[0] |=> narrow_pad.oe_n[0] && uart1_receive_in[0] ==
      $past(nsync2_q[0]))
      else $error("narrow input pin not released");

   chk_func_route: assert property (
      nfs_q[0] && ndir_q[0] && !nodt_q[0] |=> !narrow_pad.oe_n[0] &&
      narrow_pad.out[0] == $past(uart1_transmit_out))
      else $error("uart1 transmit not routed");

   chk_od_release: assert property (
      ndir_q[0] && nodt_q[0] && !nfs_q[0] && nlat_q[0] |=>
      narrow_pad.oe_n[0])
      else $error("open drain drove high");

   chk_pull_on: assert property (
      npu_q[1] && (!ndir_q[1] || nodt_q[1]) |=> narrow_pad.pull_en[1])
      else $error("pull-up not connected");

   chk_pull_pp_off: assert property (
      ndir_q[0] && !nodt_q[0] |=> !narrow_pad.pull_en[0])
      else $error("pull-up on in push-pull");

   chk_narrow_read: assert property (
      access && !pwrite && !pready_q && h_nprd && ndir_q[1] &&
      !nodt_q[1] |=> pready && prdata[1] == 1'b0)
      else $error("push-pull pin read not zero");

   chk_wide_rsvd: assert property (
      wdir_q[3:0] == 4'h0 && wlat_q[3:0] == 4'h0 && wfs_q[7] == 1'b0)
      else $error("reserved wide bits set");

   chk_wide_drive: assert property (
      wdir_q[7] && !wodt_q[7] |=> !wide_pad.oe_n[7] &&
      wide_pad.out[7] == $past(wlat_q[7]))
      else $error("wide latch not driven");

   chk_wide_sclk: assert property (
      wfs_q[6] && wdir_q[6] |=> wide_pad.out[6] ==
      $past(serial_clock_line))
      else $error("serial clock not routed");

   chk_wide_read: assert property (
      access && !pwrite && !pready_q && h_wprd && !wdir_q[4] |=>
      prdata[4] == $past(wsync2_q[4]))
      else $error("wide input pin read wrong");

   chk_latch_write: assert property (
      wr_fire && h_nlat |=> nlat_q[1:0] == $past(pwdata[1:0]) &&
      nlat_q[7:2] == 6'h00)
      else $error("narrow latch write lost");

   chk_apb_wait: assert property (
      access && !pready_q |=> pready ##1 !pready)
      else $error("apb answer timing wrong");

endmodule

// File: gtsp_top_test.sv
// Self-checking bench for the two-port GPIO
`timescale 1ns/10ps
`include "gtsp_defs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
   errors++; $display("FAIL %s exp %h got %h", nm, e, g); end end

module gtsp_top_test;
   logic clock, rst, psel, penable, pwrite, pready, pslverr, err;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, wide_pin_in;
   logic [1:0] narrow_pin_in, uart1_receive_in;
   logic u1tx, u0tx, sclk, sdo, b4sel, uart0_receive_in, serial_data_in;
   logic [7:0] n_ext, n_en, w_ext, w_en;
   gtsp_pkg::gtsp_pad_t narrow_pad, wide_pad;
   logic [13:0] idx_t [9];
   logic [7:0] msk_t [9];
   int errors = 0;
   int total_checks = 0;

   gtsp_top gtsp_top_i (.clock(clock), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .narrow_pin_in(narrow_pin_in), .wide_pin_in(wide_pin_in),
      .uart1_transmit_out(u1tx), .uart0_transmit_out(u0tx),
      .serial_clock_line(sclk), .serial_data_out(sdo),
      .wide_b4_serial_sel(b4sel), .narrow_pad(narrow_pad),
      .wide_pad(wide_pad), .uart1_receive_in(uart1_receive_in),
      .uart0_receive_in(uart0_receive_in), .serial_data_in(serial_data_in));
   gtsp_pins gtsp_pins_i (.clock(clock), .narrow_pad(narrow_pad),
      .wide_pad(wide_pad), .n_ext(n_ext), .n_en(n_en), .w_ext(w_ext),
      .w_en(w_en), .narrow_pin_in(narrow_pin_in), .wide_pin_in(wide_pin_in));

   // 100 MHz system clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // One APB transfer; waits for pready, the watchdog ends a hang
   task automatic apb(input logic w, input logic [13:0] idx,
      input logic [7:0] wd);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdx(input logic [13:0] idx, input logic [7:0] e,
      input string nm);
      apb(1'b0, idx, 8'h00);
      `CHK(nm, {24'h000000, e}, rd)
   endtask

   // Pads follow in one edge, pins need three through the synchroniser
   task automatic settle;
      repeat (4) @(posedge clock);
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      final_report;
   end

   initial begin
      rst = 1'b1;
      {psel, penable, pwrite} = 3'b000;
      {u1tx, u0tx, sclk, sdo, b4sel} = 5'b00000;
      {n_ext, n_en, w_ext, w_en} = 32'h00000000;
      paddr = 16'h0000;
      pwdata = 32'h00000000;
      pstrb = 4'hf;
      idx_t = '{`GTSP_IDX_NLAT, `GTSP_IDX_WLAT, `GTSP_IDX_NDIR,
         `GTSP_IDX_WDIR, `GTSP_IDX_NPU, `GTSP_IDX_NFS, `GTSP_IDX_WFS,
         `GTSP_IDX_NODT, `GTSP_IDX_WODT};
      msk_t = '{8'h03, 8'hf0, 8'h03, 8'hf0, 8'h03, 8'h03, 8'h70, 8'h03,
         8'hf0};
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      // Reset values, then writable bits only
      for (int i = 0; i < 9; i++) begin
         rdx(idx_t[i], 8'h00, "reset");
         apb(1'b1, idx_t[i], 8'hff);
         rdx(idx_t[i], msk_t[i], "mask");
         apb(1'b1, idx_t[i], 8'h00);
      end
      `CHK("oe idle", 8'hff, narrow_pad.oe_n)
      apb(1'b0, 14'h0100, 8'h00);
      `CHK("unmapped", 33'h100000000, {err, rd})
      apb(1'b1, `GTSP_IDX_NPRD, 8'hff);
      `CHK("ro write", 1'b0, err)
      // A write without the low byte strobe must leave the latch alone
      pstrb <= 4'he;
      apb(1'b1, `GTSP_IDX_NLAT, 8'h03);
      pstrb <= 4'hf;
      rdx(`GTSP_IDX_NLAT, 8'h00, "no strobe");
      $display("test registers done");
      // Narrow port push-pull, open drain, transmit select, input
      apb(1'b1, `GTSP_IDX_NDIR, 8'h03);
      apb(1'b1, `GTSP_IDX_NLAT, 8'h01);
      apb(1'b1, `GTSP_IDX_NPU, 8'h03);
      settle;
      `CHK("n oe", 2'b00, narrow_pad.oe_n[1:0])
      `CHK("n out", 2'b01, narrow_pad.out[1:0])
      `CHK("n pull pp", 2'b00, narrow_pad.pull_en[1:0])
      `CHK("n rx idle", 2'b11, uart1_receive_in)
      rdx(`GTSP_IDX_NPRD, 8'h00, "n pp read");
      apb(1'b1, `GTSP_IDX_NODT, 8'h03);
      settle;
      `CHK("n od oe", 2'b01, narrow_pad.oe_n[1:0])
      `CHK("n od pull", 2'b11, narrow_pad.pull_en[1:0])
      rdx(`GTSP_IDX_NPRD, 8'h01, "n od read");
      apb(1'b1, `GTSP_IDX_NODT, 8'h00);
      apb(1'b1, `GTSP_IDX_NFS, 8'h01);
      settle;
      `CHK("n tx lo", 2'b00, narrow_pad.out[1:0])
      u1tx <= 1'b1;
      settle;
      `CHK("n tx hi", 2'b01, narrow_pad.out[1:0])
      apb(1'b1, `GTSP_IDX_NDIR, 8'h00);
      n_en <= 8'h03;
      n_ext <= 8'h02;
      settle;
      rdx(`GTSP_IDX_NPRD, 8'h02, "n in read");
      `CHK("n rx", 2'b10, uart1_receive_in)
      `CHK("n in pull", 2'b11, narrow_pad.pull_en[1:0])
      $display("test narrow done");
      // Wide port push-pull, open drain, serial select, input
      apb(1'b1, `GTSP_IDX_WDIR, 8'hf0);
      apb(1'b1, `GTSP_IDX_WLAT, 8'ha0);
      settle;
      `CHK("w oe", 4'h0, wide_pad.oe_n[7:4])
      `CHK("w out", 4'ha, wide_pad.out[7:4])
      `CHK("w rx idle", 2'b11, {uart0_receive_in, serial_data_in})
      rdx(`GTSP_IDX_WPRD, 8'h00, "w pp read");
      apb(1'b1, `GTSP_IDX_WODT, 8'h30);
      w_en <= 8'hf0;
      w_ext <= 8'hf0;
      settle;
      rdx(`GTSP_IDX_WPRD, 8'h20, "w od read");
      `CHK("w pull", 8'h00, wide_pad.pull_en)
      apb(1'b1, `GTSP_IDX_WODT, 8'h00);
      apb(1'b1, `GTSP_IDX_WFS, 8'h70);
      sclk <= 1'b1;
      sdo <= 1'b1;
      b4sel <= 1'b1;
      settle;
      `CHK("w sel sd", 4'hd, wide_pad.out[7:4])
      b4sel <= 1'b0;
      settle;
      `CHK("w sel tx", 4'hc, wide_pad.out[7:4])
      apb(1'b1, `GTSP_IDX_WDIR, 8'h00);
      w_ext <= 8'h90;
      settle;
      rdx(`GTSP_IDX_WPRD, 8'h90, "w in read");
      `CHK("w rx", 2'b00, {uart0_receive_in, serial_data_in})
      $display("test wide done");
      final_report;
   end
endmodule
